// >>> arm_monitor.sv
// result monitor: two threshold-compare channels with apb registers and interrupt
//
// Function
// - channel 0 active only when enable set
// - channel 0 direction: below or above compare
// - channel 0 source: slots 0-7 or priority
// - channel 1 active only when enable set
// - channel 1 direction: below or above compare
// - channel 1 source: slots 0-7 or priority
`timescale 1ns/1ps
module rmc_monitor #(
  parameter int unsigned RES_WIDTH = rmc_pkg::RES_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [rmc_pkg::NUM_SLOTS-1:0] result_store,
  input wire logic [rmc_pkg::NUM_SLOTS*RES_WIDTH-1:0] result_slots,
  input wire logic prio_store,
  input wire logic [RES_WIDTH-1:0] priority_result_slot,
  output logic [1:0] mon_hit,
  output logic irq
);
  import rmc_pkg::*;

  logic [7:0] mode_reg [2];
  logic [RES_WIDTH-1:0] cmp_reg [2];
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [1:0] hit_next;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // selected slot value and its store strobe for a 4-bit source code
  function automatic logic [RES_WIDTH:0] pick_slot(
    input logic [3:0] sel,
    input logic [NUM_SLOTS-1:0] st,
    input logic [NUM_SLOTS*RES_WIDTH-1:0] vals,
    input logic pst,
    input logic [RES_WIDTH-1:0] pval
  );
    logic [RES_WIDTH:0] r;
    r = {pst, pval};
    if (!sel[BIT_SEL_PRIO]) begin
      r = {st[sel[2:0]], vals[sel[2:0]*RES_WIDTH +: RES_WIDTH]};
    end
    return r;
  endfunction : pick_slot

  assign addr_ok = (paddr == OFF_MON0_MODE) || (paddr == OFF_MON1_MODE) ||
                   (paddr == OFF_CMP0) || (paddr == OFF_CMP1) ||
                   (paddr == OFF_IRQ_STATUS) || (paddr == OFF_IRQ_MASK);
  // zero-wait slave; unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg[0] <= MODE_RESET;
      mode_reg[1] <= MODE_RESET;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == OFF_MON0_MODE) begin
        mode_reg[0] <= pwdata[7:0] & MODE0_WMASK;
      end
      if (paddr == OFF_MON1_MODE) begin
        mode_reg[1] <= pwdata[7:0] & MODE1_WMASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_reg[0] <= CMP_RESET;
      cmp_reg[1] <= CMP_RESET;
    end else if (wr_en) begin
      if (paddr == OFF_CMP0) begin
        cmp_reg[0] <= pwdata[RES_WIDTH-1:0];
      end
      if (paddr == OFF_CMP1) begin
        cmp_reg[1] <= pwdata[RES_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= IRQ_RESET;
    end else if (wr_en && pstrb[0] && paddr == OFF_IRQ_MASK) begin
      mask_reg <= pwdata[1:0];
    end
  end

  // per-channel comparison; equal values never fire in either direction
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [RES_WIDTH:0] pick;
    logic below;
    logic above;
    assign pick = pick_slot(mode_reg[c][BIT_SEL_HI:BIT_SEL_LO], result_store,
                            result_slots, prio_store, priority_result_slot);
    assign below = pick[RES_WIDTH-1:0] < cmp_reg[c];
    assign above = pick[RES_WIDTH-1:0] > cmp_reg[c];
    assign hit_next[c] = mode_reg[c][BIT_ENABLE] && pick[RES_WIDTH] &&
                         (mode_reg[c][BIT_DIR] ? above : below);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_hit <= 2'b00;
    end else begin
      mon_hit <= hit_next;
    end
  end

  // a hit in the clearing cycle wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= IRQ_RESET;
    end else begin
      status_reg <= (status_reg & ~((wr_en && pstrb[0] && paddr == OFF_IRQ_STATUS)
                    ? pwdata[1:0] : 2'b00)) | hit_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        OFF_MON0_MODE: prdata[7:0] <= mode_reg[0];
        OFF_MON1_MODE: prdata[7:0] <= mode_reg[1];
        OFF_CMP0: prdata[RES_WIDTH-1:0] <= cmp_reg[0];
        OFF_CMP1: prdata[RES_WIDTH-1:0] <= cmp_reg[1];
        OFF_IRQ_STATUS: prdata[1:0] <= status_reg;
        OFF_IRQ_MASK: prdata[1:0] <= mask_reg;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // assertions
  mon0_disabled_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mode_reg[0][BIT_ENABLE] |=> !mon_hit[0])
    else $error("channel 0 hit while disabled");
  mon1_disabled_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mode_reg[1][BIT_ENABLE] |=> !mon_hit[1])
    else $error("channel 1 hit while disabled");
  mon0_below_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_reg[0] == 8'h01 && result_store[0] && result_slots[RES_WIDTH-1:0] < cmp_reg[0])
    |=> mon_hit[0] && status_reg[0])
    else $error("channel 0 missed below hit");
  mon1_above_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_reg[1] == 8'h21 && result_store[0] && result_slots[RES_WIDTH-1:0] > cmp_reg[1])
    |=> mon_hit[1])
    else $error("channel 1 missed above hit");
  mon0_prio_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_reg[0][BIT_SEL_HI] && !prio_store) |=> !mon_hit[0])
    else $error("channel 0 hit without priority store");
  mon1_slot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!mode_reg[1][BIT_SEL_HI] && !result_store[mode_reg[1][3:1]]) |=> !mon_hit[1])
    else $error("channel 1 hit without slot store");
  hit_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mon_hit[0] |-> status_reg[0])
    else $error("hit did not set status");
  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == |(status_reg & mask_reg))
    else $error("irq not tied to masked status");
  status_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && pstrb[0] && paddr == OFF_IRQ_STATUS && pwdata[0] && !hit_next[0])
    |=> !status_reg[0])
    else $error("write one did not clear status");
  mon0_hit_c: cover property (@(posedge pclk) disable iff (!presetn) mon_hit[0]);
  mon1_hit_c: cover property (@(posedge pclk) disable iff (!presetn) mon_hit[1]);
  irq_rise_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : rmc_monitor

// >>> arm_pkg.sv
// package: register map, field layout and reset values of the result monitor block
package rmc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned RES_W = 10;
  localparam logic [ADDR_W-1:0] OFF_MON0_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_MON1_MODE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CMP0 = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_CMP1 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h014;
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_SEL_LO = 1;
  localparam int unsigned BIT_SEL_HI = 4;
  localparam int unsigned BIT_DIR = 5;
  localparam int unsigned BIT_WR0 = 7;
  localparam int unsigned BIT_SEL_PRIO = 3;
  localparam logic [7:0] MODE0_WMASK = 8'hBF;
  localparam logic [7:0] MODE1_WMASK = 8'h3F;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [RES_W-1:0] CMP_RESET = 10'h000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int unsigned NUM_SLOTS = 8;
  localparam int unsigned PRIO_SLOT = 8;
endpackage : rmc_pkg

// >>> arm_monitor_tb.sv
// bench for the result monitor: registers, channel compares, interrupt
`timescale 1ns/1ps
module adc_result_monitor_config_tb_top;
  import rmc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, prio_store = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, irq, serr;
  logic [NUM_SLOTS-1:0] result_store = '0;
  logic [NUM_SLOTS*RES_W-1:0] result_slots = '0, sl;
  logic [RES_W-1:0] priority_result_slot = '0, v, c0, c1;
  logic [1:0] mon_hit, est, msk, clr, eh;
  logic [7:0] m0, m1;
  int err_total = 0, n_compared = 0, k;
  always #2.5 pclk = ~pclk;
  rmc_monitor rmc_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .result_store(result_store),
    .result_slots(result_slots), .prio_store(prio_store),
    .priority_result_slot(priority_result_slot), .mon_hit(mon_hit), .irq(irq));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  // expected hit of one channel for a store into slot s
  function automatic logic hx(logic [7:0] m, logic [RES_W-1:0] x, logic [RES_W-1:0] c, int s);
    int w;
    w = m[4] ? PRIO_SLOT : int'(m[3:1]);
    if (!m[0] || w != s) return 1'b0;
    return m[5] ? (x > c) : (x < c);
  endfunction : hx
  task automatic test_done();
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    err_total++;
    test_done();
  end
  initial begin
    void'($urandom(43));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(0, OFF_MON0_MODE + ADDR_W'(4 * i), 0);
      chk("reset", 0, rd);
    end
    apb(0, 12'h018, 32'hFFFF_FFFF);
    chk("unmapped", 32'h0000_0001, {rd[30:0], serr});
    est = 0;
    for (int i = 0; i < 80; i++) begin
      m0 = 8'($urandom) & 8'h3F;
      m1 = 8'($urandom) & 8'h3F;
      // first pass walks every source code on both channels
      if (i < 16) begin
        m0[4:1] = 4'(i);
        m1[4:1] = 4'(15 - i);
        m0[0] = 1;
        m1[0] = 1;
      end
      c0 = RES_W'($urandom);
      c1 = RES_W'($urandom);
      msk = 2'($urandom);
      apb(1, OFF_MON0_MODE, {24'h0, m0});
      apb(1, OFF_MON1_MODE, {24'h0, m1});
      apb(1, OFF_CMP0, {22'h0, c0});
      apb(1, OFF_CMP1, {22'h0, c1});
      apb(1, OFF_IRQ_MASK, {30'h0, msk});
      apb(0, OFF_MON0_MODE, 0);
      chk("mode0", {24'h0, m0}, rd);
      apb(0, OFF_MON1_MODE, 0);
      chk("mode1", {24'h0, m1}, rd);
      k = (i < 16) ? (m0[4] ? PRIO_SLOT : int'(m0[3:1])) : int'($urandom_range(0, 8));
      v = RES_W'($urandom);
      if (i % 3 == 0) v = c0;
      if (i % 3 == 1) v = c0 + RES_W'(i % 2 ? 1 : -1);
      sl = (NUM_SLOTS*RES_W)'({$urandom, $urandom, $urandom});
      if (k < PRIO_SLOT) sl[k*RES_W +: RES_W] = v;
      eh = {hx(m1, v, c1, k), hx(m0, v, c0, k)};
      result_slots <= sl;
      priority_result_slot <= v;
      prio_store <= (k == PRIO_SLOT);
      result_store <= (k < PRIO_SLOT) ? NUM_SLOTS'(1 << k) : '0;
      @(posedge pclk);
      result_store <= '0;
      prio_store <= 0;
      #1 chk("hit0", eh[0], mon_hit[0]);
      chk("hit1", eh[1], mon_hit[1]);
      est |= eh;
      chk("irq", |(est & msk), irq);
      apb(0, OFF_IRQ_STATUS, 0);
      chk("status", {30'h0, est}, rd);
      clr = 2'($urandom);
      apb(1, OFF_IRQ_STATUS, {30'h0, clr});
      est &= ~clr;
      chk("irq_clr", |(est & msk), irq);
    end
    test_done();
  end
endmodule : adc_result_monitor_config_tb_top
